/* rtl/tsr_pkg.sv */
/*
  Constants shared by the timing signal router: signal counts, source codes,
  timebase figures and reset values.
  Assumes a 200 MHz system clock; the timebase half-period count is derived from it and TB_HZ.
*/
package tsr_pkg;

  // Counts of routable signals, pins and bus lines.
  localparam int N_SIG  = 13;
  localparam int N_PFI  = 10;
  localparam int N_TRIG = 7;
  localparam int N_DRV  = 8;
  localparam int N_SRC  = 32;
  localparam int SEL_W  = 5;
  localparam int DRV_W  = 3;
  localparam int CNT_W  = 16;

  // Source codes seen by every source selector.
  localparam logic [SEL_W-1:0] SRC_TRIG0 = 5'h00;
  localparam logic [SEL_W-1:0] SRC_PFI0  = 5'h07;
  localparam logic [SEL_W-1:0] SRC_SI_TC = 5'h11;
  localparam logic [SEL_W-1:0] SRC_CTR0  = 5'h12;

  // Indices of named timing signals; timing signal k drives pin k.
  localparam int SIG_CONVERT = 0;
  localparam int SIG_UPDATE  = 5;

  // Timebase figures.
  localparam longint CLK_HZ      = 64'd200_000_000;
  localparam longint TB_HZ       = 64'd20_000_000;
  localparam int     TB_HALF_CYC = int'(CLK_HZ / (2 * TB_HZ));

  // Reset values.
  localparam logic              TB_EXT_RST = 1'b0;
  localparam logic              EXPORT_RST = 1'b0;
  localparam logic [N_PFI-1:0]  PFI_OE_RST = 10'h000;
  localparam logic [N_TRIG-1:0] TRIG_OE_RST = 7'h00;
  localparam logic [N_SIG-1:0]  SIG_RST    = 13'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0000;

endpackage

/* rtl/tsr_timing_signal_router.sv */
/*
  Timing signal router: per-signal source selectors, pin and bus-line output
  drivers, master timebase selection and export, and the two internal timing
  counters that run off the selected timebase.
  Assumes configuration inputs come from logic on clk; pins, trigger lines and
  the received timebase are asynchronous and are synchronised here.
*/
module tsr_timing_signal_router #(
  parameter logic BACKPLANE = 1'b0,
  parameter int   CNT_W     = tsr_pkg::CNT_W
) (
  input  wire logic                                     clk,
  input  wire logic                                     arst_n,
  input  wire logic                                     clk_en,
  input  wire logic                                     sync_clk_i,
  input  wire logic [tsr_pkg::N_PFI-1:0]                programmable_function_pin_i,
  output logic      [tsr_pkg::N_PFI-1:0]                programmable_function_pin_o,
  output logic      [tsr_pkg::N_PFI-1:0]                programmable_function_pin_oe,
  input  wire logic [tsr_pkg::N_TRIG-1:0]               board_sync_bus_i,
  output logic      [tsr_pkg::N_TRIG-1:0]               board_sync_bus_o,
  output logic      [tsr_pkg::N_TRIG-1:0]               board_sync_bus_oe,
  output logic                                          sync_clk_o,
  output logic                                          ribbon_clk_oe,
  output logic                                          bp_trig7_oe,
  input  wire logic [tsr_pkg::N_SIG*tsr_pkg::SEL_W-1:0] sig_src_sel,
  input  wire logic [tsr_pkg::N_PFI-1:0]                pfi_oe_en,
  input  wire logic [tsr_pkg::N_TRIG-1:0]               trig_oe_en,
  input  wire logic [tsr_pkg::N_TRIG*tsr_pkg::DRV_W-1:0] trig_drv_sel,
  input  wire logic                                     tb_sel_ext,
  input  wire logic                                     tb_export_en,
  input  wire logic [CNT_W-1:0]                         si_period,
  input  wire logic [CNT_W-1:0]                         ctr0_period,
  output logic      [tsr_pkg::N_SIG-1:0]                timing_sig,
  output logic                                          tb_tick,
  output logic                                          tb_ext_active
);

  localparam int HC_W = 4;
  localparam logic [HC_W-1:0] HC_LAST = HC_W'(tsr_pkg::TB_HALF_CYC - 1);

  logic [tsr_pkg::N_PFI-1:0]  pfi_s1_r;
  logic [tsr_pkg::N_PFI-1:0]  pfi_s2_r;
  logic [tsr_pkg::N_TRIG-1:0] trig_s1_r;
  logic [tsr_pkg::N_TRIG-1:0] trig_s2_r;
  logic                       rx_tog_r;
  logic                       rx_s1_r;
  logic                       rx_s2_r;
  logic                       rx_s3_r;
  logic                       rx_edge;
  logic [HC_W-1:0]            hc_r;
  logic                       tb_half_r;
  logic                       int_tick;
  logic                       tb_tick_nxt;
  logic                       tb_ext_r;
  logic [CNT_W-1:0]           si_cnt_r;
  logic                       si_tc_r;
  logic [CNT_W-1:0]           ctr0_cnt_r;
  logic                       ctr0_out_r;
  logic [tsr_pkg::N_SRC-1:0]  src_vec;
  logic [tsr_pkg::N_SIG-1:0]  timing_sig_r;
  logic [tsr_pkg::N_PFI-1:0]  pfi_o_r;
  logic [tsr_pkg::N_PFI-1:0]  pfi_oe_r;
  logic [tsr_pkg::N_TRIG-1:0] trig_o_r;
  logic [tsr_pkg::N_TRIG-1:0] trig_oe_r;
  logic                       sync_clk_o_r;
  logic                       ribbon_clk_oe_r;
  logic                       bp_trig7_oe_r;
  logic                       tb_tick_r;
  logic [HC_W-1:0]            tick_gap_r;
  logic                       tick_seen_r;

  // One bit out of a source vector; shared by the signal and line selectors.
  function automatic logic pick_src(input logic [tsr_pkg::N_SRC-1:0] v,
                                    input logic [tsr_pkg::SEL_W-1:0] s);
    return v[s];
  endfunction

  // Pins and trigger lines are asynchronous to clk.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pfi_s1_r  <= '0;
      pfi_s2_r  <= '0;
      trig_s1_r <= '0;
      trig_s2_r <= '0;
    end else if (clk_en) begin
      pfi_s1_r  <= programmable_function_pin_i;
      pfi_s2_r  <= pfi_s1_r;
      trig_s1_r <= board_sync_bus_i;
      trig_s2_r <= trig_s1_r;
    end
  end

  // Received timebase domain: each rising edge flips a toggle that clk then samples.
  // The link clock may stop; nothing here waits for a further edge.
  always_ff @(posedge sync_clk_i or negedge arst_n) begin
    if (!arst_n) begin
      rx_tog_r <= 1'b0;
    end else begin
      rx_tog_r <= ~rx_tog_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_r <= 1'b0;
      rx_s2_r <= 1'b0;
      rx_s3_r <= 1'b0;
    end else if (clk_en) begin
      rx_s1_r <= rx_tog_r;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  assign rx_edge = rx_s2_r ^ rx_s3_r;

  // Internal 20 MHz timebase, made from clk by a half-period counter.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hc_r      <= '0;
      tb_half_r <= 1'b0;
    end else if (clk_en) begin
      if (hc_r == HC_LAST) begin
        hc_r      <= '0;
        tb_half_r <= ~tb_half_r;
      end else begin
        hc_r <= hc_r + 4'h1;
      end
    end
  end

  assign int_tick = (hc_r == HC_LAST) && !tb_half_r;

  // Checking aid: enabled cycles since the last internal tick.
  // A counter keeps the period check short instead of unrolling a long repetition.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_gap_r  <= '0;
      tick_seen_r <= 1'b0;
    end else if (clk_en) begin
      tick_seen_r <= tick_seen_r | int_tick;
      if (int_tick) begin
        tick_gap_r <= '0;
      end else if (tick_gap_r != '1) begin
        tick_gap_r <= tick_gap_r + 1'b1;
      end
    end
  end

  // The received timebase is used only when software asks for it.
  assign tb_tick_nxt = tb_ext_r ? rx_edge : int_tick;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tb_ext_r        <= tsr_pkg::TB_EXT_RST;
      ribbon_clk_oe_r <= tsr_pkg::EXPORT_RST;
      bp_trig7_oe_r   <= tsr_pkg::EXPORT_RST;
      sync_clk_o_r    <= 1'b0;
      tb_tick_r       <= 1'b0;
    end else if (clk_en) begin
      tb_ext_r        <= tb_sel_ext;
      // Export is refused while the board itself runs off the received clock.
      ribbon_clk_oe_r <= tb_export_en && !tb_sel_ext && !BACKPLANE;
      bp_trig7_oe_r   <= tb_export_en && !tb_sel_ext && BACKPLANE;
      sync_clk_o_r    <= tb_half_r;
      tb_tick_r       <= tb_tick_nxt;
    end
  end

  // Both counters advance on every selected timebase tick, undivided.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      si_cnt_r <= tsr_pkg::CNT_RST;
      si_tc_r  <= 1'b0;
    end else if (clk_en) begin
      si_tc_r <= 1'b0;
      if (tb_tick_nxt) begin
        if (si_cnt_r == '0) begin
          si_cnt_r <= si_period;
          si_tc_r  <= 1'b1;
        end else begin
          si_cnt_r <= si_cnt_r - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctr0_cnt_r <= tsr_pkg::CNT_RST;
      ctr0_out_r <= 1'b0;
    end else if (clk_en) begin
      if (tb_tick_nxt) begin
        if (ctr0_cnt_r == '0) begin
          ctr0_cnt_r <= ctr0_period;
          ctr0_out_r <= ~ctr0_out_r;
        end else begin
          ctr0_cnt_r <= ctr0_cnt_r - 1'b1;
        end
      end
    end
  end

  // Unused source codes read as zero.
  always_comb begin
    src_vec = '0;
    src_vec[tsr_pkg::SRC_TRIG0 +: tsr_pkg::N_TRIG] = trig_s2_r;
    src_vec[tsr_pkg::SRC_PFI0 +: tsr_pkg::N_PFI]   = pfi_s2_r;
    src_vec[tsr_pkg::SRC_SI_TC]                    = si_tc_r;
    src_vec[tsr_pkg::SRC_CTR0]                     = ctr0_out_r;
  end

  // Every signal selector reads the same source vector, so sharing a pin is free.
  for (genvar k = 0; k < tsr_pkg::N_SIG; k++) begin : g_sig
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        timing_sig_r[k] <= tsr_pkg::SIG_RST[k];
      end else if (clk_en) begin
        timing_sig_r[k] <= pick_src(src_vec, sig_src_sel[k*tsr_pkg::SEL_W +: tsr_pkg::SEL_W]);
      end
    end
  end

  // Timing signal k drives pin k; a disabled driver also holds its data low.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pfi_o_r  <= '0;
      pfi_oe_r <= tsr_pkg::PFI_OE_RST;
    end else if (clk_en) begin
      pfi_o_r  <= timing_sig_r[tsr_pkg::N_PFI-1:0] & pfi_oe_en;
      pfi_oe_r <= pfi_oe_en;
    end
  end

  // A driven trigger line also loops back through its input synchroniser.
  for (genvar t = 0; t < tsr_pkg::N_TRIG; t++) begin : g_trig
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        trig_o_r[t]  <= 1'b0;
        trig_oe_r[t] <= tsr_pkg::TRIG_OE_RST[t];
      end else if (clk_en) begin
        trig_o_r[t]  <= trig_oe_en[t] && pick_src({{(tsr_pkg::N_SRC-tsr_pkg::N_SIG){1'b0}},
                        timing_sig_r}, {2'h0, trig_drv_sel[t*tsr_pkg::DRV_W +: tsr_pkg::DRV_W]});
        trig_oe_r[t] <= trig_oe_en[t];
      end
    end
  end

  assign programmable_function_pin_o  = pfi_o_r;
  assign programmable_function_pin_oe = pfi_oe_r;
  assign board_sync_bus_o             = trig_o_r;
  assign board_sync_bus_oe            = trig_oe_r;
  assign sync_clk_o                   = sync_clk_o_r;
  assign ribbon_clk_oe                = ribbon_clk_oe_r;
  assign bp_trig7_oe                  = bp_trig7_oe_r;
  assign timing_sig                   = timing_sig_r;
  assign tb_tick                      = tb_tick_r;
  assign tb_ext_active                = tb_ext_r;

  chk_conv_route: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> timing_sig_r[tsr_pkg::SIG_CONVERT] == $past(src_vec[sig_src_sel[4:0]]))
    else $error("conversion strobe does not follow its selected source");

  chk_pin_shared: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && sig_src_sel[4:0] == sig_src_sel[9:5] && sig_src_sel[4:0] >= tsr_pkg::SRC_PFI0
     && sig_src_sel[4:0] < tsr_pkg::SRC_SI_TC) |=> timing_sig_r[0] == timing_sig_r[1])
    else $error("two signals sharing one pin disagree");

  chk_pin_reach: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && sig_src_sel[64:60] == 5'h10) |=> timing_sig_r[12] == $past(pfi_s2_r[9]))
    else $error("last pin does not reach last signal");

  chk_update_pin: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en ##1 (clk_en && pfi_oe_en[5]) |=>
      pfi_oe_r[5] && pfi_o_r[5] == $past(src_vec[sig_src_sel[29:25]], 2))
    else $error("update pin does not carry its strobe");

  chk_int_period: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && tick_seen_r) |-> int_tick == (tick_gap_r == HC_W'(2 * tsr_pkg::TB_HALF_CYC - 1)))
    else $error("internal timebase tick is not every ten cycles");

  chk_int_select: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && !tb_ext_r) |=> tb_tick_r == $past(int_tick))
    else $error("internal timebase tick not passed on");

  chk_pin_drive: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> pfi_o_r == ($past(timing_sig_r[tsr_pkg::N_PFI-1:0]) & pfi_oe_r))
    else $error("pin does not carry its fixed timing signal");

  chk_export_on: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> ribbon_clk_oe_r == $past(tb_export_en && !tb_sel_ext && !BACKPLANE))
    else $error("timebase export does not follow its enable");

  chk_si_reload: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && tb_tick_nxt && si_cnt_r == '0) |=> si_tc_r && si_cnt_r == $past(si_period))
    else $error("interval counter missed its reload on a tick");

  chk_tb_select: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && tb_ext_r && rx_edge) |=> tb_tick_r)
    else $error("received timebase tick lost");

  chk_export_gate: assert property (@(posedge clk) disable iff (!arst_n)
    (ribbon_clk_oe_r || bp_trig7_oe_r) |-> !tb_ext_r && !(ribbon_clk_oe_r && bp_trig7_oe_r))
    else $error("timebase exported while received one is in use");

  chk_bp_line: assert property (@(posedge clk) disable iff (!arst_n)
    bp_trig7_oe_r |-> BACKPLANE)
    else $error("trigger line 7 driven on a ribbon build");

  chk_reset_quiet: assert property (@(posedge clk)
    $rose(arst_n) |-> !tb_ext_r && !ribbon_clk_oe_r && !bp_trig7_oe_r
      && pfi_oe_r == '0 && trig_oe_r == '0)
    else $error("driver or timebase not idle after reset");

  chk_trig_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_en && !trig_oe_en[0]) |=> !trig_oe_r[0] && !trig_o_r[0])
    else $error("disabled trigger line still driven");

  cov_pin_conv: cover property (@(posedge clk) disable iff (!arst_n)
    sig_src_sel[4:0] == tsr_pkg::SRC_PFI0 ##1 timing_sig_r[0]);

  cov_ext_tb: cover property (@(posedge clk) disable iff (!arst_n)
    tb_ext_r && tb_tick_r);

  cov_export: cover property (@(posedge clk) disable iff (!arst_n)
    ribbon_clk_oe_r && sync_clk_o_r);

  cov_trig_out: cover property (@(posedge clk) disable iff (!arst_n)
    trig_oe_r[6] && trig_o_r[6]);

  cov_shared_pin: cover property (@(posedge clk) disable iff (!arst_n)
    sig_src_sel[4:0] == sig_src_sel[9:5] ##1 timing_sig_r[0] && timing_sig_r[1]);

endmodule

/* testbench/tsr_far_board.sv */
/*
  Far-side model: another board sharing the sync trigger lines and the timebase link.
  Assumes the bench hands it the device's line drivers and the exported clock wire.
*/
module tsr_far_board (
  input  wire logic       run,
  input  wire logic       rx_cfg,
  input  wire logic [6:0] far_val,
  input  wire logic [6:0] far_oe,
  input  wire logic [6:0] dev_o,
  input  wire logic [6:0] dev_oe,
  input  wire logic       dev_clk,
  output logic      [6:0] bus_lvl,
  output logic            link_clk,
  output int              rx_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  // An unheld line wanders, so a stale level can never pass for a driven one.
  always #3 flip = ~flip;
  // Each line is two-way: the device drives it or this board does.
  assign bus_lvl = (dev_oe & dev_o) | (~dev_oe & far_oe & far_val) | (~dev_oe & ~far_oe & {7{flip}});
  // The link clock runs only within a frame and stands low between frames.
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever begin
      #16;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
  // The exported timebase is used only once this board is set to take it.
  initial begin
    rx_edges = 0;
    forever @(posedge dev_clk) if (rx_cfg) rx_edges++;
  end
endmodule

/* testbench/timing_signal_router_tb.sv */
/*
  Self-checking bench for the timing signal router with a queue-free integer model.
  Assumes the far-side board model and the design package are compiled first.
*/
module timing_signal_router_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS = tsr_pkg::N_SIG;
  logic [tsr_pkg::N_PFI-1:0] programmable_function_pin_i = '0, pfi_oe_en = '0;
  logic [tsr_pkg::N_PFI-1:0] programmable_function_pin_o, programmable_function_pin_oe;
  logic [tsr_pkg::N_TRIG-1:0] board_sync_bus_i, board_sync_bus_o, board_sync_bus_oe, exp_bus;
  logic [tsr_pkg::N_TRIG-1:0] trig_oe_en = '0, far_val = '0, far_oe = '0;
  logic [tsr_pkg::N_SIG*tsr_pkg::SEL_W-1:0] sig_src_sel = '0;
  logic [tsr_pkg::N_TRIG*tsr_pkg::DRV_W-1:0] trig_drv_sel = '0;
  logic [15:0] si_period = '0, ctr0_period = '0;
  logic [NS-1:0] timing_sig, exp_sig;
  logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, sync_clk_i, sync_clk_o;
  logic ribbon_clk_oe, bp_trig7_oe, tb_tick, tb_ext_active, run = 1'b0, rx_cfg = 1'b0;
  logic tb_sel_ext = 1'b0, tb_export_en = 1'b0, drv;
  logic [1:0] prev = '0;
  logic [31:0] rnd = 32'h8502354a;
  int rx_edges, err_total = 0, comparisons = 0, cyc = 0, ticks = 0, n0 = 0, n1 = 0, edges;
  int src [NS];

  tsr_timing_signal_router tsr_timing_signal_router_i (
    .clk                          (clk),
    .arst_n                       (arst_n),
    .clk_en                       (clk_en),
    .sync_clk_i                   (sync_clk_i),
    .programmable_function_pin_i  (programmable_function_pin_i),
    .programmable_function_pin_o  (programmable_function_pin_o),
    .programmable_function_pin_oe (programmable_function_pin_oe),
    .board_sync_bus_i             (board_sync_bus_i),
    .board_sync_bus_o             (board_sync_bus_o),
    .board_sync_bus_oe            (board_sync_bus_oe),
    .sync_clk_o                   (sync_clk_o),
    .ribbon_clk_oe                (ribbon_clk_oe),
    .bp_trig7_oe                  (bp_trig7_oe),
    .sig_src_sel                  (sig_src_sel),
    .pfi_oe_en                    (pfi_oe_en),
    .trig_oe_en                   (trig_oe_en),
    .trig_drv_sel                 (trig_drv_sel),
    .tb_sel_ext                   (tb_sel_ext),
    .tb_export_en                 (tb_export_en),
    .si_period                    (si_period),
    .ctr0_period                  (ctr0_period),
    .timing_sig                   (timing_sig),
    .tb_tick                      (tb_tick),
    .tb_ext_active                (tb_ext_active)
  );
  tsr_far_board tsr_far_board_i (.run(run), .rx_cfg(rx_cfg), .far_val(far_val),
    .far_oe(far_oe), .dev_o(board_sync_bus_o), .dev_oe(board_sync_bus_oe),
    .dev_clk(sync_clk_o & ribbon_clk_oe), .bus_lvl(board_sync_bus_i),
    .link_clk(sync_clk_i), .rx_edges(rx_edges));

  initial forever #2.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (tb_tick === 1'b1) ticks++;
    n0 += int'(timing_sig[0] === 1'b1 && prev[0] === 1'b0);
    n1 += int'(timing_sig[1] !== prev[1]);
    prev <= timing_sig[1:0];
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    wait_n(2);
    arst_n = 1'b1;
    wait_n(1);
    cmp_vec(programmable_function_pin_oe, 0);
    cmp_vec(board_sync_bus_oe, 0);
    cmp_vec({tb_ext_active, ribbon_clk_oe, bp_trig7_oe}, 0);
    $display("test reset done");
    // Odd passes drive pins and lines, so sources then come from pins only to avoid loops.
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      drv = i[0];
      far_oe = '1;
      far_val = rnd[6:0];
      programmable_function_pin_i = rnd[16:7];
      pfi_oe_en = drv ? rnd[26:17] : '0;
      trig_oe_en = drv ? rnd[31:25] : '0;
      for (int k = 0; k < NS; k++) begin
        rnd = lfsr(rnd);
        src[k] = (i % 8 == 2) ? 7 + i % 10 : drv ? 7 + rnd % 10 : rnd % 17;
        sig_src_sel[5*k +: 5] = 5'(src[k]);
        exp_sig[k] = src[k] < 7 ? far_val[src[k]] : programmable_function_pin_i[src[k]-7];
        if (k < 7) trig_drv_sel[3*k +: 3] = rnd[10:8];
      end
      for (int t = 0; t < 7; t++) exp_bus[t] = exp_sig[trig_drv_sel[3*t +: 3]] & trig_oe_en[t];
      wait_n(6);
      cmp_vec(timing_sig, exp_sig);
      cmp_vec(programmable_function_pin_oe, pfi_oe_en);
      cmp_vec(programmable_function_pin_o, exp_sig[9:0] & pfi_oe_en);
      cmp_vec(board_sync_bus_oe, trig_oe_en);
      cmp_vec(board_sync_bus_o, exp_bus);
    end
    // The last pass routes pins only, so inverted pins invert every timing signal.
    clk_en = 1'b0;
    programmable_function_pin_i = ~programmable_function_pin_i;
    wait_n(6);
    cmp_vec(timing_sig, exp_sig);
    clk_en = 1'b1;
    exp_sig = ~exp_sig;
    wait_n(6);
    cmp_vec(timing_sig, exp_sig);
    $display("test routing done");
    pfi_oe_en = '0;
    trig_oe_en = '0;
    sig_src_sel[4:0] = tsr_pkg::SRC_SI_TC;
    sig_src_sel[9:5] = tsr_pkg::SRC_CTR0;
    si_period = 16'h0003;
    ctr0_period = 16'h0001;
    wait_n(50);
    {ticks, n0, n1} = '0;
    wait_n(400);
    cmp_cnt(ticks, 40, 40);
    cmp_cnt(n0, 9, 11);
    cmp_cnt(n1, 19, 21);
    $display("test internal timing done");
    {tb_sel_ext, tb_export_en, run, rx_cfg} = 4'hf;
    wait_n(20);
    cmp_vec({tb_ext_active, ribbon_clk_oe, bp_trig7_oe}, 3'h4);
    {ticks, edges} = {32'd0, rx_edges};
    wait_n(640);
    cmp_cnt(ticks, 99, 101);
    cmp_cnt(rx_edges - edges, 0, 0);
    run = 1'b0;
    wait_n(10);
    ticks = 0;
    wait_n(50);
    cmp_cnt(ticks, 0, 0);
    tb_sel_ext = 1'b0;
    wait_n(20);
    cmp_vec({tb_ext_active, ribbon_clk_oe, bp_trig7_oe}, 3'h2);
    edges = rx_edges;
    wait_n(100);
    cmp_cnt(rx_edges - edges, 9, 11);
    rx_cfg = 1'b0;
    edges = rx_edges;
    wait_n(100);
    cmp_cnt(rx_edges - edges, 0, 0);
    tb_export_en = 1'b0;
    wait_n(5);
    cmp_vec(ribbon_clk_oe, 0);
    $display("test timebase done");
    stop_test();
  end
endmodule
